//--- sdr_readout.sv
// sdr_readout: latched diagnostics of six low-side stages, read out as the
// device end of a 16-clock serial frame.
// assumes the master's clock, select and data arrive unsynchronised and the
// serial clock runs well below a quarter of clock_i (80 ns in the bench).
// a stage code must stand two clocks to be seen: shorter blips are ignored,
// the price of never latching a half-changed code as a false fault.
//
// Summary of operation
// RQ1: The second diagnostic byte holds stage 4, 3, 2, 1 codes in bit pairs 7-6, 5-4, 3-2, 1-0.
// RQ2: The second output byte is the lower diagnostic byte unless a control or select readback was asked.
// RQ3: Latched faults clear only after a diagnostic-read instruction in a frame of exactly 16 clocks, or during reset.
// RQ4: Bits 7 and 6 of the first diagnostic byte are never driven on the serial output.
// RQ5: The first diagnostic byte holds the stage 6 code in bits 3-2 and stage 5 in bits 1-0.
// RQ6: The first diagnostic byte has the fault flag at bit 5 and over-temperature at bit 4, both low on fault.
// RQ7: Stage codes are 11 healthy, 10 overload or short to battery or hot, 01 open load, 00 short to ground.
// RQ8: The first output byte of every frame is the flag and stage 6 and 5 byte.
// RQ9: The over-temperature flag latches the OR of the six stage temperature sensors.
// RQ10: The fault flag shows a fault on any one or more of the six stages.
// RQ11: Latched diagnostics reset at the select rising edge ending a diagnostic read, or during reset.
// RQ12: A received command takes effect at the select rising edge, never at a clock edge.
// RQ13: A frame whose count of falling clock edges is not exactly 16 gives no command and no clear, though its bits are still shifted out.
module sdr_readout
   import sdr_pkg::*;
#(
   parameter logic [7:0] CMD_READ_DIAG = 8'h00,
   parameter logic [7:0] CMD_READ_SERIAL_CTRL = 8'h01,
   parameter logic [7:0] CMD_READ_SELECT = 8'h02
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic [11:0] stage_code_i,
   input wire logic [5:0] stage_overtemp_i,
   input wire logic [5:0] serial_ctrl_readback_i,
   input wire logic [5:0] select_readback_i,
   output logic cmd_valid_o,
   output sdr_cmd_t cmd_o,
   output logic diag_cleared_o,
   output logic [7:0] channel_status_low_o,
   output logic [7:0] channel_status_high_flags_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic stage_faulty(input logic [1:0] code);
      return code != CODE_OK;
   endfunction

   // a latched fault is held; a healthy slot takes whatever is live now
   function automatic logic [1:0] latch_code(input logic [1:0] held, input logic [1:0] live,
                                             input logic clr);
      if (clr || !stage_faulty(held)) begin
         return live;
      end
      return held;
   endfunction

   // edges of a sampled pin: old is the later stage, cur the earlier one
   function automatic logic went_low(input logic old, input logic cur);
      return old & ~cur;
   endfunction

   function automatic logic went_high(input logic old, input logic cur);
      return ~old & cur;
   endfunction

   // the last instruction bit still waits at the data sync when this is asked
   function automatic logic instr_is(input logic [6:0] head, input logic tail,
                                     input logic [7:0] code);
      return (head == code[7:1]) && (tail == code[0]);
   endfunction

   // register readback: six stage bits, then the two low filler bits
   function automatic logic [7:0] readback_byte(input logic [5:0] bits);
      return {bits, READBACK_PAD};
   endfunction

   // bits 7 and 6 of the first byte are left undriven
   function automatic logic drives_bit(input logic [3:0] idx);
      return (idx != HIZ_IDX_HI) && (idx != HIZ_IDX_LO);
   endfunction

   // a slot takes the live code only when two synchronised samples agree
   function automatic logic [11:0] settle_codes(input logic [11:0] held,
                                                input logic [11:0] cur,
                                                input logic [11:0] prev);
      logic [11:0] res;
      res = held;
      for (int i = 0; i < NUM_STAGES; i++) begin
         if (cur[2*i +: 2] == prev[2*i +: 2]) begin
            res[2*i +: 2] = cur[2*i +: 2];
         end
      end
      return res;
   endfunction

   function automatic logic no_fault(input logic [11:0] codes);
      logic res;
      res = 1'b1;
      for (int i = 0; i < NUM_STAGES; i++) begin
         res = res & ~stage_faulty(codes[2*i +: 2]);
      end
      return res;
   endfunction

   sdr_state_t q;
   sdr_state_t d;

   logic sclk_fall;
   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;
   logic frame_ok;
   logic clr;
   logic any_hot;
   logic [7:0] low_byte;
   logic [7:0] high_byte;
   logic [7:0] instr;
   logic [7:0] second_byte;
   logic [3:0] out_idx;

   // ----------------------------------------------------------------
   // assembled diagnostic bytes
   // ----------------------------------------------------------------
   always_comb begin
      // stage codes pass through untouched in the 11/10/01/00 encoding
      low_byte = q.codes[7:0]; // [RQ1] [RQ7]
      high_byte = {HIZ_PAD, q.fault_n, q.overtemp_n, q.codes[11:8]}; // [RQ5] [RQ6]
   end

   assign channel_status_low_o = low_byte;
   assign channel_status_high_flags_o = high_byte;

   // ----------------------------------------------------------------
   // edges of the sampled serial pins
   // ----------------------------------------------------------------
   assign sclk_fall = went_low(q.sclk_s3, q.sclk_s2) & ~q.cs_b_s2;
   assign sclk_rise = went_high(q.sclk_s3, q.sclk_s2) & ~q.cs_b_s2;
   assign cs_fall = went_low(q.cs_b_s3, q.cs_b_s2);
   assign cs_rise = went_high(q.cs_b_s3, q.cs_b_s2);
   assign frame_ok = (q.cnt == FRAME_BITS); // [RQ13]
   assign instr = q.in_sh[15:8];
   assign clr = cs_rise & frame_ok & (instr == CMD_READ_DIAG); // [RQ3] [RQ11]
   assign any_hot = |q.temp_s2;
   assign out_idx = FIRST_OUT_IDX - q.cnt[3:0];

   // instruction bits are all in once the eighth falling edge is taken
   always_comb begin
      if (instr_is(q.in_sh[6:0], q.si_s2, CMD_READ_SERIAL_CTRL)) begin
         second_byte = readback_byte(serial_ctrl_readback_i);
      end else if (instr_is(q.in_sh[6:0], q.si_s2, CMD_READ_SELECT)) begin
         second_byte = readback_byte(select_readback_i);
      end else begin
         second_byte = q.out_sh[7:0]; // [RQ2]
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.sclk_s1 = sclk_i;
      d.sclk_s2 = q.sclk_s1;
      d.sclk_s3 = q.sclk_s2;
      d.cs_b_s1 = cs_b_i;
      d.cs_b_s2 = q.cs_b_s1;
      d.cs_b_s3 = q.cs_b_s2;
      d.si_s1 = si_i;
      d.si_s2 = q.si_s1;
      d.temp_s1 = stage_overtemp_i;
      d.temp_s2 = q.temp_s1;
      d.code_s1 = stage_code_i;
      d.code_s2 = q.code_s1;
      d.code_s3 = q.code_s2;
      d.code_f = settle_codes(q.code_f, q.code_s2, q.code_s3);
      d.cmd_stb = 1'b0;
      d.clr_stb = 1'b0;

      // a fault present in the clearing cycle is re-latched, not lost
      for (int i = 0; i < NUM_STAGES; i++) begin
         d.codes[2*i +: 2] = latch_code(q.codes[2*i +: 2], q.code_f[2*i +: 2], clr); // [RQ3]
      end
      d.fault_n = no_fault(d.codes); // [RQ10]
      if (clr) begin
         d.overtemp_n = ~any_hot; // [RQ9] [RQ11]
         d.clr_stb = 1'b1;
      end else begin
         d.overtemp_n = q.overtemp_n & ~any_hot; // [RQ9]
      end

      if (cs_fall) begin
         // snapshot so a fault arriving mid-frame cannot tear the bytes
         d.out_sh = {high_byte, low_byte}; // [RQ8]
         d.cnt = 5'h00;
         d.so = high_byte[7];
         d.so_oe = 1'b0; // [RQ4]
      end else if (sclk_fall) begin
         d.in_sh = {q.in_sh[14:0], q.si_s2};
         if (q.cnt != CNT_SAT) begin
            d.cnt = q.cnt + 5'h01;
         end
         if (q.cnt == BYTE_BITS - 5'h01) begin
            d.out_sh[7:0] = second_byte; // [RQ2]
         end
      end else if (sclk_rise) begin
         if (q.cnt < FRAME_BITS && q.cnt != 5'h00) begin
            d.so = q.out_sh[out_idx];
            d.so_oe = drives_bit(out_idx); // [RQ4]
         end else if (q.cnt >= FRAME_BITS) begin
            d.so_oe = 1'b0;
         end
      end

      if (cs_rise) begin
         d.so_oe = 1'b0;
         // commands act only here, and only for a whole 16-clock frame
         if (frame_ok) begin // [RQ12] [RQ13]
            d.cmd_stb = 1'b1;
            d.cmd.code = q.in_sh[15:8];
            d.cmd.data = q.in_sh[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.sclk_s1 <= 1'b0;
         q.cs_b_s1 <= 1'b1;
         q.cs_b_s2 <= 1'b1;
         q.cs_b_s3 <= 1'b1;
         q.codes <= CODES_RESET; // [RQ11]
         // syncs start healthy, else the first clocks would latch short to ground
         q.code_s1 <= CODES_RESET;
         q.code_s2 <= CODES_RESET;
         q.code_s3 <= CODES_RESET;
         q.code_f <= CODES_RESET;
         q.fault_n <= FLAG_NO_FAULT;
         q.overtemp_n <= FLAG_NO_FAULT;
         q.out_sh <= {STATUS_HIGH_RESET, STATUS_LOW_RESET};
      end else begin
         q <= d;
      end
   end

   assign so_o = q.so;
   assign so_oe_o = q.so_oe;
   assign cmd_valid_o = q.cmd_stb;
   assign cmd_o = q.cmd;
   assign diag_cleared_o = q.clr_stb;

endmodule

//--- sdr_pkg.sv
// sdr_pkg: constants and types of the six-stage diagnostic serial readout.
// assumes one 200 MHz clock; serial pins are sampled, not used as clocks.
package sdr_pkg;

   // ----------------------------------------------------------------
   // frame and field layout
   // ----------------------------------------------------------------
   localparam int unsigned NUM_STAGES = 6;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam logic [4:0] CNT_SAT = 5'h1F;
   localparam logic [3:0] FIRST_OUT_IDX = 4'hF;
   localparam logic [3:0] HIZ_IDX_HI = 4'hF;
   localparam logic [3:0] HIZ_IDX_LO = 4'hE;
   localparam logic [1:0] READBACK_PAD = 2'h3;
   localparam logic [1:0] HIZ_PAD = 2'h3;

   // ----------------------------------------------------------------
   // status encoding and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CODE_OK = 2'h3;
   localparam logic [1:0] CODE_OVERLOAD = 2'h2;
   localparam logic [1:0] CODE_OPEN_LOAD = 2'h1;
   localparam logic [1:0] CODE_SHORT_GND = 2'h0;
   localparam logic [11:0] CODES_RESET = 12'hFFF;
   localparam logic [7:0] STATUS_LOW_RESET = 8'hFF;
   localparam logic [7:0] STATUS_HIGH_RESET = 8'hFF;
   localparam logic FLAG_NO_FAULT = 1'b1;

   // received command handed to the control registers outside
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] data;
   } sdr_cmd_t;

   // whole state of the readout block
   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic cs_b_s1;
      logic cs_b_s2;
      logic cs_b_s3;
      logic si_s1;
      logic si_s2;
      logic [5:0] temp_s1;
      logic [5:0] temp_s2;
      logic [11:0] code_s1;
      logic [11:0] code_s2;
      logic [11:0] code_s3;
      logic [11:0] code_f;
      logic [11:0] codes;
      logic fault_n;
      logic overtemp_n;
      logic [4:0] cnt;
      logic [15:0] out_sh;
      logic [15:0] in_sh;
      logic so;
      logic so_oe;
      logic cmd_stb;
      sdr_cmd_t cmd;
      logic clr_stb;
   } sdr_state_t;

endpackage

//--- sdr_props.sv
// sdr_props: port timing checks of sdr_readout.
// assumes serial pins change at least four clocks apart.
module sdr_props
   import sdr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic si_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   input wire logic [11:0] stage_code_i,
   input wire logic [5:0] stage_overtemp_i,
   input wire logic [5:0] serial_ctrl_readback_i,
   input wire logic [5:0] select_readback_i,
   input wire logic cmd_valid_o,
   input wire sdr_cmd_t cmd_o,
   input wire logic diag_cleared_o,
   input wire logic [7:0] channel_status_low_o,
   input wire logic [7:0] channel_status_high_flags_o
);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence cs_start;
      $fell(cs_b_i);
   endsequence
   a_hiz_lead: assert property (cs_start |-> !so_oe_o [*8])
      else $error("output driven in leading bits");
   a_reset_ff: assert property (disable iff (1'b0) !rst_b_i && $past(!rst_b_i) |->
      channel_status_low_o == STATUS_LOW_RESET && channel_status_high_flags_o == STATUS_HIGH_RESET)
      else $error("status not reset");
   a_fault_flag: assert property (channel_status_high_flags_o[5] ==
      (channel_status_low_o == 8'hFF && channel_status_high_flags_o[3:0] == 4'hF))
      else $error("fault flag wrong");
   a_ot_sticky: assert property (!cs_b_i && !channel_status_high_flags_o[4] |=>
      !channel_status_high_flags_o[4])
      else $error("overtemp not held");
   a_ot_latch: assert property ($rose(|stage_overtemp_i) |->
      ##[1:5] !channel_status_high_flags_o[4])
      else $error("overtemp not latched");
   a_codes_hold: assert property (!cs_b_i && channel_status_low_o[7:6] != CODE_OK |=>
      $stable(channel_status_low_o[7:6]))
      else $error("stage code not held");
   a_clear_cmd: assert property (diag_cleared_o |-> cmd_valid_o && cs_b_i)
      else $error("clear without frame end");
   a_cmd_at_rise: assert property (cmd_valid_o |-> cs_b_i && $past(cs_b_i, 2))
      else $error("command not at select rise");
endmodule
bind sdr_readout sdr_props u_props (.clock_i, .rst_b_i, .sclk_i, .cs_b_i, .si_i, .so_o,
   .so_oe_o, .stage_code_i, .stage_overtemp_i, .serial_ctrl_readback_i, .select_readback_i,
   .cmd_valid_o, .cmd_o, .diag_cleared_o, .channel_status_low_o, .channel_status_high_flags_o);

//--- sdr_master.sv
// sdr_master: serial master model sending frames of a given clock count.
// assumes an 80 ns serial clock that idles low between frames.
module sdr_master (
   input wire logic clock_i,
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sclk_o,
   output logic cs_b_o,
   output logic si_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic line;
   initial begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      si_o = 1'b0;
      line = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx,
         output logic [15:0] en);
      rx = '0;
      en = '0;
      cs_b_o <= 1'b0;
      for (int k = 0; k < n; k++) begin
         wt(8);
         sclk_o <= 1'b1;
         si_o <= tx[15 - k];
         wt(8);
         // released line reads as the inverse of its last level
         line = so_oe_i ? so_i : ~line;
         rx[15 - k] = line;
         en[15 - k] = so_oe_i;
         sclk_o <= 1'b0;
      end
      wt(8);
      cs_b_o <= 1'b1;
      wt(8);
   endtask
endmodule

//--- tb_top.sv
// tb_top: frame-level checks of sdr_readout through the master model.
// assumes the 200 MHz clock and the hand-over latencies of the block.
module tb_top;
   import sdr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_b_i;
   logic sclk, cs_b, si, so, oe, vld, clr;
   logic [11:0] code = CODES_RESET;
   logic [5:0] hot = 6'h00;
   logic [5:0] scon_rb = 6'h2A;
   logic [5:0] sel_rb = 6'h15;
   logic [7:0] lo, hi;
   logic [15:0] rx, en;
   sdr_cmd_t cmd;
   int error_cnt = 0, comparisons = 0, vcnt = 0, ccnt = 0;
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      vcnt <= vcnt + int'(vld);
      ccnt <= ccnt + int'(clr);
   end
   sdr_readout #(.CMD_READ_DIAG(8'h00), .CMD_READ_SERIAL_CTRL(8'h01), .CMD_READ_SELECT(8'h02))
   dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .si_i(si),
      .so_o(so), .so_oe_o(oe), .stage_code_i(code), .stage_overtemp_i(hot),
      .serial_ctrl_readback_i(scon_rb), .select_readback_i(sel_rb), .cmd_valid_o(vld),
      .cmd_o(cmd), .diag_cleared_o(clr), .channel_status_low_o(lo),
      .channel_status_high_flags_o(hi));
   sdr_master m (.clock_i(clock_i), .so_i(so), .so_oe_i(oe), .sclk_o(sclk), .cs_b_o(cs_b),
      .si_o(si));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clock_i);
      error_cnt++;
      summarize();
   end
   initial begin
      rst_b_i = 1'b0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      m.wt(6);
      chk({hi, lo}, {STATUS_HIGH_RESET, STATUS_LOW_RESET});
      code <= 12'h1B4;
      hot <= 6'h04;
      m.wt(4);
      code <= CODES_RESET;
      hot <= 6'h00;
      m.wt(8);
      chk(lo, 8'hB4);
      chk(hi, 8'hC1);
      $display("latch test done");
      for (int i = 0; i < 2; i++) begin
         // the register not asked for holds a different pattern, so a wrong pick shows
         scon_rb <= i ? 6'h3F : 6'h2A;
         sel_rb <= i ? 6'h15 : 6'h00;
         m.frame({i ? 8'h02 : 8'h01, 8'h5A}, 16, rx, en);
         chk(en, 16'h3FFF);
         chk(rx[13:0], {6'h01, i ? 8'h57 : 8'hAB});
         m.wt(10);
      end
      chk(16'(vcnt), 16'h0002);
      chk(cmd, 16'h025A);
      m.frame(16'h0000, 15, rx, en);
      m.wt(10);
      chk(16'(vcnt), 16'h0002);
      chk(lo, 8'hB4);
      $display("readback test done");
      m.frame(16'h00A5, 16, rx, en);
      chk(rx[7:0], 8'hB4);
      m.wt(10);
      chk({hi, lo}, 16'hFFFF);
      chk(16'(ccnt), 16'h0001);
      code <= 12'hFFE;
      m.wt(8);
      chk(lo, 8'hFE);
      rst_b_i <= 1'b0;
      m.wt(2);
      chk(lo, 8'hFF);
      $display("clear test done");
      summarize();
   end
endmodule
